// File: scs_port.sv
// Clock-stop serial port core with master shift clock generator and slave link logic.
`timescale 1ns/10ps
`default_nettype none
`include "scs_defs.svh"
// What this block does
// [RQ1] Master shift clock period is (1 + divide value) processor clock periods.
// [RQ2] High phase is half period when divide odd/zero, else divide/2+1 cycles.
// [RQ3] Low phase is half period when divide odd/zero, else divide/2 cycles.
// [RQ4] Slave mode needs sample clock source select and divide value both set to one.
// [RQ5] Frame polarities are one; master drives an active-low select on its frame pin.
// [RQ6] Slave inverts the active-low select on both frame pins before internal use.
// [RQ7] Master: transmit clock and frame are outputs, receive clock and frame inputs.
// [RQ8] Slave: all four clock and frame directions are inputs.
// [RQ9] Select goes low before the active clock edge; transfer starts on master edge.
// [RQ10] Master select falls one high phase (10b) or one period (11b) before first fall.
// [RQ11] Master select stays low one period (10b) or one high phase (11b) after last rise.
// [RQ12] Mode 10b launches each transmit bit on the falling shift clock edge.
// [RQ13] Mode 11b launches each transmit bit on the rising shift clock edge.
// [RQ14] Mode 11b samples receive data on the falling edge as master and slave.
// [RQ15] Master 10b releases transmit data one high phase after the final rise.
// [RQ16] Slave 10b releases transmit data once select returns high.
// [RQ17] Selected slave drives its first bit on select fall, before any clock edge; the slave enables its data pin three system cycles after select fall.
// [RQ18] Only framed data bits are clocked; the shift clock stays stopped when idle.
module scs_port #(
   parameter int WORD_W = 8,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic CLK_SYS_I,
   input wire logic SYS_RST_I,
   input wire logic TX_CLOCK_IS_OUTPUT_I,
   input wire logic RX_CLOCK_IS_OUTPUT_I,
   input wire logic TX_FRAME_IS_OUTPUT_I,
   input wire logic RX_FRAME_IS_OUTPUT_I,
   input wire logic FRAME_POLARITY_TX_I,
   input wire logic FRAME_POLARITY_RX_I,
   input wire logic TX_CLOCK_POLARITY_I,
   input wire logic SAMPLE_CLOCK_SOURCE_SELECT_I,
   input wire scs_pkg::scs_mode_type CLOCK_STOP_MODE_I,
   input wire logic [7:0] CLOCK_DIVIDE_VALUE_I,
   input wire logic TX_SHIFT_CLOCK_PIN_I,
   output logic TX_SHIFT_CLOCK_PIN_O,
   output logic TX_SHIFT_CLOCK_PIN_OE_O,
   input wire logic TX_FRAME_PIN_I,
   output logic TX_FRAME_PIN_O,
   output logic TX_FRAME_PIN_OE_O,
   input wire logic RX_FRAME_PIN_I,
   output logic TX_DATA_PIN_O,
   output logic TX_DATA_PIN_OE_O,
   input wire logic RX_DATA_PIN_I,
   input wire logic [WORD_W-1:0] TX_WORD_I,
   input wire logic TX_VALID_I,
   output logic TX_READY_O,
   output logic [WORD_W-1:0] RX_WORD_O,
   output logic RX_VALID_O,
   input wire logic RX_READY_I,
   output logic BUSY_O,
   output logic OVERRUN_O,
   input wire logic OVERRUN_CLR_I,
   output logic CONFIG_ERR_O
);
   import scs_pkg::*;

   localparam int IW = $clog2(WORD_W);
   localparam int CYC_PER_2P = (2 * `SCS_P_NS) / `SCS_CLK_PERIOD_NS;
   localparam logic [IW-1:0] LAST_BIT = IW'(WORD_W - 1);

   // ***************************************************************
   // Phase length decoding
   // ***************************************************************

   // Clamps the divide value so that a zero still gives whole-cycle phases.
   function automatic logic [7:0] div_eff_f(input logic [7:0] dv);
      div_eff_f = (dv < `SCS_DIV_MIN) ? `SCS_DIV_MIN : dv;
   endfunction : div_eff_f

   // Shift clock period in system cycles.
   function automatic logic [8:0] per_len_f(input logic [7:0] dv);
      per_len_f = 9'(({1'b0, div_eff_f(dv)} + `SCS_CNT_ONE) * CYC_PER_2P); // [RQ1]
   endfunction : per_len_f

   // High phase length in system cycles.
   function automatic logic [8:0] hi_len_f(input logic [7:0] dv);
      logic [7:0] d;
      d = div_eff_f(dv);
      if (d[0]) begin
         hi_len_f = 9'((({1'b0, d} + `SCS_CNT_ONE) >> 1) * CYC_PER_2P); // [RQ2]
      end else begin
         hi_len_f = 9'(({2'b0, d[7:1]} + `SCS_CNT_ONE) * CYC_PER_2P); // [RQ2]
      end
   endfunction : hi_len_f

   // Low phase length in system cycles.
   function automatic logic [8:0] lo_len_f(input logic [7:0] dv);
      logic [7:0] d;
      d = div_eff_f(dv);
      if (d[0]) begin
         lo_len_f = 9'((({1'b0, d} + `SCS_CNT_ONE) >> 1) * CYC_PER_2P); // [RQ3]
      end else begin
         lo_len_f = 9'({2'b0, d[7:1]} * CYC_PER_2P); // [RQ3]
      end
   endfunction : lo_len_f

   // ***************************************************************
   // Configuration and role
   // ***************************************************************
   logic cfg_ok_q;
   logic is_master_q;
   logic mode_delay;
   logic [8:0] hi_len;
   logic [8:0] lo_len;
   logic [8:0] per_len;

   assign mode_delay = (CLOCK_STOP_MODE_I == `SCS_MODE_DELAY);
   assign hi_len = hi_len_f(CLOCK_DIVIDE_VALUE_I);
   assign lo_len = lo_len_f(CLOCK_DIVIDE_VALUE_I);
   assign per_len = per_len_f(CLOCK_DIVIDE_VALUE_I);

   // Checks the direction, polarity and sample clock settings for the chosen role.
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         cfg_ok_q <= 1'b0;
         is_master_q <= 1'b0;
      end else begin
         is_master_q <= TX_CLOCK_IS_OUTPUT_I;
         if (TX_CLOCK_IS_OUTPUT_I) begin
            cfg_ok_q <= TX_FRAME_IS_OUTPUT_I && !RX_CLOCK_IS_OUTPUT_I && !RX_FRAME_IS_OUTPUT_I // [RQ7]
               && FRAME_POLARITY_TX_I && FRAME_POLARITY_RX_I && TX_CLOCK_POLARITY_I // [RQ5]
               && CLOCK_STOP_MODE_I[1];
         end else begin
            cfg_ok_q <= !TX_FRAME_IS_OUTPUT_I && !RX_CLOCK_IS_OUTPUT_I && !RX_FRAME_IS_OUTPUT_I // [RQ8]
               && FRAME_POLARITY_TX_I && FRAME_POLARITY_RX_I && TX_CLOCK_POLARITY_I
               && SAMPLE_CLOCK_SOURCE_SELECT_I && (CLOCK_DIVIDE_VALUE_I == `SCS_SLAVE_DIV) // [RQ4]
               && CLOCK_STOP_MODE_I[1];
         end
      end
   end

   // ***************************************************************
   // Slave link domain, clocked by the external shift clock
   // ***************************************************************
   logic sclk;
   logic [IW-1:0] l_cnt_q;
   logic l_seen_q;
   logic [IW-1:0] l_idx_q;
   logic [WORD_W-1:0] l_rxsh_q;
   logic [WORD_W-1:0] l_rxw_q;
   logic [WORD_W-1:0] l_word_q;
   logic l_rxtgl_q;
   logic l_ack_q;
   logic l_rq1_q;
   logic l_rq2_q;
   logic [WORD_W-1:0] s_stage_q;
   logic s_req_q;

   // Rising edge of this clock is the sampling edge, falling edge the launch edge.
   assign sclk = TX_SHIFT_CLOCK_PIN_I ^ mode_delay; // [RQ14]

   // Bit counter, cleared while the receive select is high.
   always_ff @(posedge sclk or posedge RX_FRAME_PIN_I) begin
      if (RX_FRAME_PIN_I) begin
         l_cnt_q <= '0; // [RQ6]
         l_seen_q <= 1'b0;
      end else begin
         l_cnt_q <= (l_cnt_q == LAST_BIT) ? '0 : l_cnt_q + 1'b1;
         l_seen_q <= 1'b1;
      end
   end

   // Receive shifting, word hand-off and transmit word pick-up.
   always_ff @(posedge sclk or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         l_rxsh_q <= '0;
         l_rxw_q <= '0;
         l_word_q <= '0;
         l_rxtgl_q <= 1'b0;
         l_ack_q <= 1'b0;
         l_rq1_q <= 1'b0;
         l_rq2_q <= 1'b0;
      end else begin
         l_rxsh_q <= {l_rxsh_q[WORD_W-2:0], RX_DATA_PIN_I}; // [RQ14]
         l_rq1_q <= s_req_q;
         l_rq2_q <= l_rq1_q;
         if (l_cnt_q == LAST_BIT) begin
            l_rxw_q <= {l_rxsh_q[WORD_W-2:0], RX_DATA_PIN_I};
            l_rxtgl_q <= !l_rxtgl_q;
            if (l_rq2_q != l_ack_q) begin
               l_word_q <= s_stage_q;
               l_ack_q <= !l_ack_q;
            end
         end
      end
   end

   // Launch index; the first launch edge before any sample keeps bit zero.
   always_ff @(negedge sclk or posedge TX_FRAME_PIN_I) begin
      if (TX_FRAME_PIN_I) begin
         l_idx_q <= '0;
      end else if (l_seen_q) begin
         l_idx_q <= (l_idx_q == LAST_BIT) ? '0 : l_idx_q + 1'b1; // [RQ12] [RQ13]
      end
   end

   // ***************************************************************
   // Slave side in the system domain
   // ***************************************************************
   logic s_sel1_q;
   logic s_sel2_q;
   logic s_ack1_q;
   logic s_ack2_q;
   logic s_rx1_q;
   logic s_rx2_q;
   logic s_rx3_q;
   logic s_full_q;
   logic s_load;

   assign s_load = !is_master_q && TX_VALID_I && TX_READY_O;

   // Synchronisers for the inverted select, the word toggle and the acknowledge.
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         {s_sel1_q, s_sel2_q, s_ack1_q, s_ack2_q} <= '0;
         {s_rx1_q, s_rx2_q, s_rx3_q} <= '0;
      end else begin
         s_sel1_q <= !TX_FRAME_PIN_I; // [RQ6]
         s_sel2_q <= s_sel1_q;
         s_ack1_q <= l_ack_q;
         s_ack2_q <= s_ack1_q;
         s_rx1_q <= l_rxtgl_q;
         s_rx2_q <= s_rx1_q;
         s_rx3_q <= s_rx2_q;
      end
   end

   // Staging register holding the next slave word until the link picks it up.
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         s_stage_q <= '0;
         s_req_q <= 1'b0;
         s_full_q <= 1'b0;
      end else if (s_load) begin
         s_stage_q <= TX_WORD_I;
         s_req_q <= !s_req_q;
         s_full_q <= 1'b1;
      end else if (s_ack2_q == s_req_q) begin
         s_full_q <= 1'b0;
      end
   end

   // ***************************************************************
   // Master sequencer
   // ***************************************************************
   scs_state_type state_q;
   logic [8:0] cnt_q;
   logic [IW-1:0] bit_q;
   logic sck_q;
   logic sel_n_q;
   logic oe_q;
   logic rdy_q;
   logic [WORD_W-1:0] m_tx_q;
   logic [WORD_W-1:0] m_rx_q;
   logic m_rx1_q;
   logic m_rx2_q;
   logic m_done;
   logic m_stb_q;
   logic m_stb2_q;
   logic m_dn1_q;
   logic m_dn2_q;
   logic m_start;

   assign m_start = is_master_q && TX_VALID_I && rdy_q;

   // Receive pin synchroniser; the sample strobe and the end of frame are delayed to match its two stages.
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         m_rx1_q <= 1'b0;
         m_rx2_q <= 1'b0;
         m_stb2_q <= 1'b0;
         m_dn1_q <= 1'b0;
         m_dn2_q <= 1'b0;
         m_rx_q <= '0;
      end else begin
         m_rx1_q <= RX_DATA_PIN_I;
         m_rx2_q <= m_rx1_q;
         m_stb2_q <= m_stb_q;
         m_dn1_q <= m_done;
         m_dn2_q <= m_dn1_q;
         if (m_stb2_q) begin
            m_rx_q <= {m_rx_q[WORD_W-2:0], m_rx2_q}; // [RQ14]
         end
      end
   end

   scs_fifo_if #(.WIDTH(WORD_W)) fif ();

   // Clock stays high and select high while idle; phases are counted in system cycles.
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         state_q <= ST_IDLE;
         cnt_q <= `SCS_CNT_ONE;
         bit_q <= '0;
         sck_q <= `SCS_IDLE_HIGH;
         sel_n_q <= `SCS_IDLE_HIGH;
         oe_q <= 1'b0;
         rdy_q <= 1'b0;
         m_tx_q <= '0;
         m_stb_q <= 1'b0;
      end else begin
         m_stb_q <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               sck_q <= `SCS_IDLE_HIGH; // [RQ18]
               sel_n_q <= `SCS_IDLE_HIGH;
               cnt_q <= `SCS_CNT_ONE;
               bit_q <= '0;
               if (!is_master_q) begin
                  oe_q <= s_sel2_q && cfg_ok_q; // [RQ16] [RQ17]
                  rdy_q <= cfg_ok_q && !s_full_q && !s_load;
               end else if (m_start) begin
                  sel_n_q <= 1'b0; // [RQ5] [RQ9]
                  oe_q <= 1'b1;
                  rdy_q <= 1'b0;
                  m_tx_q <= TX_WORD_I;
                  state_q <= ST_LEAD;
               end else begin
                  oe_q <= 1'b0;
                  rdy_q <= cfg_ok_q && fif.in_ready;
               end
            end
            ST_LEAD: begin
               if (cnt_q == (mode_delay ? per_len : hi_len)) begin // [RQ10]
                  sck_q <= 1'b0;
                  cnt_q <= `SCS_CNT_ONE;
                  state_q <= ST_SHIFT;
                  m_stb_q <= mode_delay; // [RQ14]
               end else begin
                  cnt_q <= cnt_q + `SCS_CNT_ONE;
               end
            end
            ST_SHIFT: begin
               if (!sck_q && cnt_q == lo_len) begin
                  sck_q <= 1'b1;
                  cnt_q <= `SCS_CNT_ONE;
                  m_stb_q <= !mode_delay;
                  if (bit_q == LAST_BIT) begin
                     state_q <= ST_TRAIL;
                     if (mode_delay) begin
                        oe_q <= 1'b0;
                     end
                  end else if (mode_delay) begin
                     m_tx_q <= {m_tx_q[WORD_W-2:0], 1'b0}; // [RQ13]
                  end
               end else if (sck_q && cnt_q == hi_len) begin
                  sck_q <= 1'b0;
                  cnt_q <= `SCS_CNT_ONE;
                  bit_q <= bit_q + 1'b1;
                  m_stb_q <= mode_delay; // [RQ14]
                  if (!mode_delay) begin
                     m_tx_q <= {m_tx_q[WORD_W-2:0], 1'b0}; // [RQ12]
                  end
               end else begin
                  cnt_q <= cnt_q + `SCS_CNT_ONE;
               end
            end
            ST_TRAIL: begin
               cnt_q <= cnt_q + `SCS_CNT_ONE;
               if (!mode_delay && cnt_q == hi_len) begin
                  oe_q <= 1'b0; // [RQ15]
               end
               if (cnt_q == (mode_delay ? hi_len : per_len)) begin // [RQ11]
                  sel_n_q <= `SCS_IDLE_HIGH;
                  oe_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   assign m_done = (state_q == ST_TRAIL) && (cnt_q == (mode_delay ? hi_len : per_len));

   // ***************************************************************
   // Receive FIFO feed and status
   // ***************************************************************
   logic push_ev;
   logic push_q;
   logic [WORD_W-1:0] push_d_q;
   logic ovr_q;
   logic busy_q;
   logic pin_oe_q;

   assign push_ev = is_master_q ? m_dn2_q : (s_rx2_q != s_rx3_q);

   // Presents each finished word to the FIFO; a slave word with no room is lost and flagged.
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         push_q <= 1'b0;
         push_d_q <= '0;
         ovr_q <= 1'b0;
         busy_q <= 1'b0;
         pin_oe_q <= 1'b0;
      end else begin
         push_q <= push_ev && fif.in_ready;
         push_d_q <= is_master_q ? m_rx_q : l_rxw_q;
         ovr_q <= (push_ev && !fif.in_ready) || (ovr_q && !OVERRUN_CLR_I);
         busy_q <= is_master_q ? (state_q != ST_IDLE) : s_sel2_q;
         pin_oe_q <= is_master_q && cfg_ok_q; // [RQ7] [RQ8]
      end
   end

   assign fif.in_valid = push_q;
   assign fif.in_data = push_d_q;
   assign fif.out_ready = RX_READY_I;

   scs_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(CLK_SYS_I),
      .rst_i(SYS_RST_I),
      .f(fif)
   );

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign TX_SHIFT_CLOCK_PIN_O = sck_q;
   assign TX_SHIFT_CLOCK_PIN_OE_O = pin_oe_q;
   assign TX_FRAME_PIN_O = sel_n_q;
   assign TX_FRAME_PIN_OE_O = pin_oe_q;
   assign TX_DATA_PIN_O = is_master_q ? m_tx_q[WORD_W-1] : l_word_q[LAST_BIT - l_idx_q]; // [RQ17]
   assign TX_DATA_PIN_OE_O = oe_q;
   assign TX_READY_O = rdy_q;
   assign RX_WORD_O = fif.out_data;
   assign RX_VALID_O = fif.out_valid;
   assign BUSY_O = busy_q;
   assign OVERRUN_O = ovr_q;
   assign CONFIG_ERR_O = !cfg_ok_q;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   logic sck_dly_q;
   logic sel_dly_q;
   logic [8:0] run_q;
   logic [8:0] lo_run_q;

   // Counts how long the shift clock has held its level since its last change or select fall, and keeps the last low.
   always_ff @(posedge CLK_SYS_I) begin
      sck_dly_q <= sck_q;
      lo_run_q <= (sck_q && !sck_dly_q) ? run_q : lo_run_q;
      sel_dly_q <= sel_n_q;
      run_q <= ((sck_q != sck_dly_q) || (!sel_n_q && sel_dly_q)) ? `SCS_CNT_ONE : run_q + `SCS_CNT_ONE;
   end

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (SYS_RST_I);

   sequence sq_start;
      state_q == ST_IDLE && m_start;
   endsequence
   sequence sq_framed_fall;
      $fell(sck_q) && $past(state_q) == ST_SHIFT;
   endsequence

   AST_IDLE_STOPPED: assert property (state_q == ST_IDLE |-> sck_q && sel_n_q) // [RQ18]
      else $error("shift clock or select active while idle");
   AST_START: assert property (sq_start |=> !sel_n_q && sck_q && oe_q ##1 !sel_n_q && state_q != ST_IDLE) // [RQ9]
      else $error("select did not lead the clock");
   AST_HIGH: assert property (sq_framed_fall |-> run_q == hi_len) // [RQ2]
      else $error("high phase length wrong");
   AST_LOW: assert property ($rose(sck_q) && !sel_n_q |-> run_q == lo_len) // [RQ3]
      else $error("low phase length wrong");
   AST_PERIOD: assert property (sq_framed_fall |-> 9'(run_q + lo_run_q) == per_len) // [RQ1]
      else $error("shift clock period wrong");
   AST_LEAD: assert property ($fell(sck_q) && $past(state_q) == ST_LEAD |-> run_q == (mode_delay ? per_len : hi_len)) // [RQ10]
      else $error("select lead time wrong");
   AST_TRAIL: assert property ($rose(sel_n_q) |-> run_q == (mode_delay ? hi_len : per_len)) // [RQ11]
      else $error("select trail time wrong");
   AST_LAUNCH: assert property (is_master_q && state_q == ST_SHIFT && $changed(m_tx_q) |-> (mode_delay ? $rose(sck_q) : $fell(sck_q))) // [RQ12] [RQ13]
      else $error("transmit bit launched on the wrong edge");
   AST_RELEASE: assert property (is_master_q && !mode_delay && $fell(oe_q) |-> sck_q && run_q == hi_len) // [RQ15]
      else $error("master data release time wrong");
   AST_SLAVE_OE: assert property (!is_master_q && !s_sel2_q |=> !oe_q) // [RQ16]
      else $error("slave kept driving after deselect");
   AST_CFG: assert property (!cfg_ok_q && state_q == ST_IDLE |=> state_q == ST_IDLE) // [RQ4] [RQ7] [RQ8]
      else $error("transfer began with illegal configuration");
endmodule : scs_port
`default_nettype wire

// File: scs_defs.svh
// Constant definitions for the clock-stop serial port.
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH
`define SCS_MODE_NO_DELAY 2'h2
`define SCS_MODE_DELAY 2'h3
`define SCS_DIV_MIN 8'h01
`define SCS_SLAVE_DIV 8'h01
`define SCS_P_NS 50
`define SCS_CLK_PERIOD_NS 100
`define SCS_CNT_ONE 9'h001
`define SCS_CNT_ZERO 9'h000
`define SCS_IDLE_HIGH 1'h1
`endif

// File: scs_pkg.sv
// Types shared by the clock-stop serial port modules.
`default_nettype none
package scs_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TRAIL} scs_state_type;
   typedef logic [1:0] scs_mode_type;
endpackage : scs_pkg
`default_nettype wire

// File: scs_fifo_if.sv
// Valid/ready carrier between the port core and its receive FIFO.
`timescale 1ns/10ps
`default_nettype none
interface scs_fifo_if #(parameter int WIDTH = 8);
   logic in_valid;
   logic in_ready;
   logic [WIDTH-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [WIDTH-1:0] out_data;
   modport fifo (input in_valid, input in_data, input out_ready, output in_ready, output out_valid, output out_data);
   modport user (output in_valid, output in_data, output out_ready, input in_ready, input out_valid, input out_data);
endinterface : scs_fifo_if
`default_nettype wire

// File: scs_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module scs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   scs_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic full;
   logic empty;

   // Pointers carry one extra bit so that full and empty differ.
   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
   assign f.in_ready = !full;
   assign f.out_valid = !empty;
   assign f.out_data = mem_q[rd_q[AW-1:0]];

   // Write side stores a word whenever the source offers one and room exists.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_q <= '0;
      end else if (f.in_valid && !full) begin
         mem_q[wr_q[AW-1:0]] <= f.in_data;
         wr_q <= wr_q + 1'b1;
      end
   end

   // Read side drops the head word when the sink takes it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_q <= '0;
      end else if (f.out_ready && !empty) begin
         rd_q <= rd_q + 1'b1;
      end
   end
endmodule : scs_fifo
`default_nettype wire

// File: scs_spi_peer.sv
// Behavioural peripheral that answers the port's master frames.
`timescale 1ns/10ps
`default_nettype none
module scs_spi_peer (
   input wire logic sel_n_i,
   input wire logic sck_i,
   input wire logic mode3_i,
   input wire logic mosi_i,
   input wire logic [7:0] reply_i,
   output logic miso_o,
   output logic [7:0] got_o
);
   logic [7:0] sh_q;
   int n;
   initial miso_o = 1'b0;
   // Load the reply at select fall and show its first bit before any clock edge.
   always @(negedge sel_n_i) begin
      sh_q = reply_i;
      n = 0;
      miso_o = reply_i[7];
   end
   // A released line shows the inverse of its last value, never a stale copy.
   always @(posedge sel_n_i) miso_o = ~miso_o;
   // Only a selected peer shifts: it samples on one edge and launches on the other.
   always @(sck_i) begin
      if (!sel_n_i && sck_i !== mode3_i) begin
         got_o = {got_o[6:0], mosi_i};
         n++;
      end else if (!sel_n_i && n > 0) begin
         sh_q = {sh_q[6:0], 1'b0};
         miso_o = sh_q[7];
      end
   end
endmodule : scs_spi_peer
`default_nettype wire

// File: tb_serial_port_spi_clock_stop.sv
// Self-checking bench of the port as master against a behavioural peripheral.
`timescale 1ns/10ps
`default_nettype none
module tb_serial_port_spi_clock_stop;
   logic clk = 1'b0, rst = 1'b1, valid = 1'b0, rdy = 1'b0, run = 1'b0;
   logic [1:0] mode = 2'h2;
   logic [4:0] cfg = 5'h0f;
   logic [7:0] div = 8'h01, word = 8'h00, reply = 8'h00, got, rx;
   logic sck_o, sck_oe, sel_o, sel_oe, dat_o, dat_oe, miso, ready, rvalid, err, busy, ovr;
   wire logic sck = sck_oe ? sck_o : 1'b1;
   wire logic sel_n = sel_oe ? sel_o : 1'b1;
   int bad_count = 0, checked = 0, falls = 0, stray = 0;
   time tt, dd, cc, t_sel, t_rise, t_fall;
   logic [7:0] exp_q[$];
   // ************************************************************
   // Clock, design and peripheral.
   // ************************************************************
   always #50 clk = ~clk;
   scs_port scs_port_inst (.CLK_SYS_I(clk), .SYS_RST_I(rst), .TX_CLOCK_IS_OUTPUT_I(1'b1),
      .RX_CLOCK_IS_OUTPUT_I(cfg[4]), .TX_FRAME_IS_OUTPUT_I(cfg[0]), .RX_FRAME_IS_OUTPUT_I(1'b0),
      .FRAME_POLARITY_TX_I(cfg[1]), .FRAME_POLARITY_RX_I(cfg[2]), .TX_CLOCK_POLARITY_I(cfg[3]),
      .SAMPLE_CLOCK_SOURCE_SELECT_I(1'b1), .CLOCK_STOP_MODE_I(mode), .CLOCK_DIVIDE_VALUE_I(div),
      .TX_SHIFT_CLOCK_PIN_I(sck), .TX_SHIFT_CLOCK_PIN_O(sck_o), .TX_SHIFT_CLOCK_PIN_OE_O(sck_oe),
      .TX_FRAME_PIN_I(sel_n), .TX_FRAME_PIN_O(sel_o), .TX_FRAME_PIN_OE_O(sel_oe), .RX_FRAME_PIN_I(1'b1),
      .TX_DATA_PIN_O(dat_o), .TX_DATA_PIN_OE_O(dat_oe), .RX_DATA_PIN_I(miso), .TX_WORD_I(word),
      .TX_VALID_I(valid), .TX_READY_O(ready), .RX_WORD_O(rx), .RX_VALID_O(rvalid), .RX_READY_I(rdy),
      .BUSY_O(busy), .OVERRUN_O(ovr), .OVERRUN_CLR_I(1'b0), .CONFIG_ERR_O(err));
   scs_spi_peer scs_spi_peer_inst (.sel_n_i(sel_n), .sck_i(sck), .mode3_i(mode[0]), .mosi_i(dat_o),
      .reply_i(reply), .miso_o(miso), .got_o(got));
   // ************************************************************
   // Compare tasks and verdict.
   // ************************************************************
   task automatic cmp_word(input string what, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, s);
      end
   endtask : cmp_word
   task automatic cmp_time(input string what, input time e, input time s);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0t seen %0t", what, e, s);
      end
   endtask : cmp_time
   task automatic results;
      if (bad_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   // Frame timing measured on the pins, against widths worked out from the divide value.
   always @(negedge sel_n) if (run) begin
      t_sel = $time;
      falls = 0;
   end
   always @(negedge sck) if (run) begin
      if (sel_n) stray++;
      else if (falls == 0) cmp_time("lead", mode[0] ? tt : dd, $time - t_sel);
      else cmp_time("high", dd, $time - t_rise);
      falls++;
      t_fall = $time;
   end
   always @(posedge sck) if (run && !sel_n) begin
      cmp_time("low", cc, $time - t_fall);
      t_rise = $time;
   end
   always @(posedge sel_n) if (run) begin
      cmp_time("trail", mode[0] ? dd : tt, $time - t_rise);
      cmp_word("falls", 8'h08, 8'(falls));
      cmp_word("data oe", 8'h00, {7'h00, dat_oe});
   end
   // One master frame: random word out, random reply back, through the FIFO.
   task automatic xfer(input logic [1:0] m, input logic [7:0] d);
      logic [7:0] w;
      int k;
      w = 8'($urandom);
      mode = m;
      div = d;
      reply = 8'($urandom);
      exp_q.push_back(reply);
      tt = (1 + d) * 100;
      dd = d[0] ? tt / 2 : (d / 2 + 1) * 100;
      cc = tt - dd;
      word = w;
      valid = 1'b1;
      for (k = 0; k < 50 && ready !== 1'b1; k++) @(negedge clk);
      @(negedge clk);
      valid = 1'b0;
      for (k = 0; k < 300 && rvalid !== 1'b1; k++) @(negedge clk);
      cmp_word("rx word", exp_q.pop_front(), rx);
      cmp_word("peer word", w, got);
      rdy = 1'b1;
      @(negedge clk);
      rdy = 1'b0;
      @(negedge clk);
   endtask : xfer
   // Watchdog cuts a hang short well beyond the expected run length.
   initial begin
      #2000000;
      bad_count++;
      results();
   end
   // Main sequence: reset, configuration check, then every mode at four divide values.
   initial begin
      void'($urandom(9));
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      run = 1'b1;
      cmp_word("config err", 8'h00, {7'h00, err});
      cmp_word("clock oe", 8'h01, {7'h00, sck_oe});
      // Each of five illegal settings in turn must flag an error, block requests and release the shift clock pin.
      for (int i = 0; i < 5; i++) begin
         cfg = 5'h0f ^ (5'h01 << i);
         repeat (3) @(negedge clk);
         valid = 1'b1;
         repeat (2) @(negedge clk);
         cmp_word("bad config err", 8'h01, {7'h00, err});
         cmp_word("bad config ready", 8'h00, {7'h00, ready});
         cmp_word("bad config clock oe", 8'h00, {7'h00, sck_oe});
         valid = 1'b0;
         cfg = 5'h0f;
      end
      repeat (3) @(negedge clk);
      cmp_word("config err", 8'h00, {7'h00, err});
      for (int m = 2; m < 4; m++) for (int d = 1; d < 5; d++) xfer(2'(m), 8'(d));
      cmp_word("idle edges", 8'h00, 8'(stray));
      results();
   end
endmodule : tb_serial_port_spi_clock_stop
`default_nettype wire
